//--- logic/pol_fault_protection.sv
`timescale 1ns/1ps
// Operation
// - any fault-group trip turns the converter off (not implemented: groupFaultIn is unused)
// - overcurrent is armed only while output is above pre-bias
// - overcurrent trip: status bit 3 reads 0, both switches off at once
// - temperature compensation of current limit is a writable bit
// - undervoltage is checked only in steady state
// - undervoltage without overcurrent: status 0, sequenced ramp-down
// - above 130 degC: overtemp fault, status 0, sequenced off
// - non-latching overtemp restarts once below 120 degC; after the 130 ms wait it restarts at or below 130 degC
// - tracking is checked only while ramping up
// - tracking error over 250 mV: status 0, both switches off
// - config bit 7 enables tracking protection
// - under and overvoltage limits follow the present setpoint
// - tracking stays off during margining moves
// - overvoltage above pre-bias: status 0, high off, low on
// - overvoltage limit 110-130 percent, min 0.5 V, setpoint+0.25 V
// - config bits 5..0 pick latching or non-latching per protection
// - non-latching faults other than overtemp retry every 130 ms with normal sequencing
// - latching faults stay off until cleared after 130 ms
// - config bit 6 enables the phase voltage check
// - propagating faults pull the group fault line low
module pol_fault_protection
   import pfp_pkg::*;
#(
   parameter int unsigned RETRY_CYCLES = RETRY_CYCLES_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData_q,
   // analog comparator trips, asynchronous
   input wire logic ocTripIn,
   input wire logic phaseErrIn,
   // measurements and sequencer state, same clock
   input wire logic [12:0] outputMv,
   input wire logic [12:0] preBiasMv,
   input wire logic [12:0] setpointMv,
   input wire logic [12:0] rampTargetMv,
   input wire logic [7:0] tempDegC,
   input wire logic [1:0] ovLevelSel,
   input wire logic [7:0] uvPct,
   input wire logic rampingUp,
   input wire logic steadyState,
   input wire logic marginMove,
   input wire logic turnOnCmd,
   input wire logic [NPROT-1:0] propagateEn,
   // converter control
   output logic converterRun_q,
   output logic seqOff_q,
   output logic fastOff_q,
   output logic crowbar_q,
   output logic tempCompEn_q,
   output logic [CL_MSB:0] curLimitCode_q,
   // group fault line, open drain
   input wire logic groupFaultIn,
   output logic groupFaultOut_q,
   output logic groupFaultOe_q
);
   typedef struct packed {
      pfp_state_type state;
      pfp_off_type offStyle;
      logic [TMR_W-1:0] timer;
      logic [NPROT-1:0] hold;
      logic [7:0] cfgA;
      logic [7:0] curLimit;
      logic turnOnPrev;
      logic [7:0] rdData;
      logic run;
      logic seqOff;
      logic fastOff;
      logic crowbar;
      logic faultOe;
   } pfp_top_state_type;

   localparam logic [TMR_W-1:0] RETRY_LOAD =
      TMR_W'(RETRY_CYCLES - 1);

   pfp_top_state_type s_q;
   pfp_top_state_type s_d;

   pfp_sync_if #(.W(2)) trips ();

   logic ocSync;
   logic phaseSync;
   logic preBiasOk;
   logic [7:0] ovPct;
   logic [20:0] ovProd;
   logic [20:0] uvProd;
   logic [13:0] ovScaled;
   logic [13:0] ovThr;
   logic [13:0] uvThr;
   logic [13:0] spPlus;
   logic [12:0] trackDiff;
   logic [NPROT-1:0] cond;
   logic [NPROT-1:0] latchSel;
   logic [NPROT-1:0] clrMask;
   logic [NPROT-1:0] newHold;
   logic turnOnFall;
   logic otHot;
   logic restartOk;
   pfp_off_type tripStyle;

   assign trips.raw = {phaseErrIn, ocTripIn};

   pfp_sync #(.W(2)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .sp(trips.sink)
   );

   assign ocSync = trips.sync[0];
   assign phaseSync = trips.sync[1];

   // thresholds move with the setpoint, so margining rescales them
   always_comb begin
      unique case (ovLevelSel)
         OV_SEL_110: ovPct = OV_PCT_110;
         OV_SEL_120: ovPct = OV_PCT_120;
         default: ovPct = OV_PCT_130;
      endcase
      ovProd = 21'(setpointMv) * 21'(ovPct);
      uvProd = 21'(setpointMv) * 21'(uvPct);
      ovScaled = 14'(ovProd / PCT_DIV);
      uvThr = 14'(uvProd / PCT_DIV);
      spPlus = 14'(setpointMv) + OV_MARGIN_MV;
      ovThr = ovScaled;
      if (ovThr < OV_FLOOR_MV) begin
         ovThr = OV_FLOOR_MV;
      end
      if (ovThr < spPlus) begin
         ovThr = spPlus;
      end
   end

   always_comb begin
      preBiasOk = outputMv > preBiasMv;
      if (outputMv > rampTargetMv) begin
         trackDiff = outputMv - rampTargetMv;
      end else begin
         trackDiff = rampTargetMv - outputMv;
      end
      otHot = tempDegC > OT_TRIP_DEGC;
      cond = '0;
      cond[FI_OC] = ocSync && preBiasOk;
      cond[FI_UV] = steadyState && !ocSync &&
         (14'(outputMv) < uvThr);
      cond[FI_OT] = otHot;
      cond[FI_TR] = s_q.cfgA[BIT_RAMP_EN] && rampingUp &&
         !marginMove && (trackDiff > TRACK_WINDOW_MV);
      cond[FI_OV] = preBiasOk &&
         (14'(outputMv) > ovThr);
      cond[FI_PV] = s_q.cfgA[BIT_PHASE_EN] && phaseSync;
   end

   // worst shutdown style among the protections now tripping
   always_comb begin
      tripStyle = OFF_NONE;
      if (cond[FI_UV] || cond[FI_OT]) begin
         tripStyle = OFF_SEQ;
      end
      if (cond[FI_OC] || cond[FI_TR] || cond[FI_PV]) begin
         tripStyle = OFF_CRIT;
      end
      if (cond[FI_OV]) begin
         tripStyle = OFF_EMER;
      end
   end

   always_comb begin
      latchSel = s_q.cfgA[NPROT-1:0];
      turnOnFall = s_q.turnOnPrev && !turnOnCmd;
      // a held fault may only clear once its cause is gone
      clrMask = '0;
      if (s_q.state == PFP_IDLE || s_q.state == PFP_WAIT) begin
         clrMask = ~latchSel & ~cond;
         if (regWrEn && regAddr == ADDR_STATUS) begin
            clrMask = clrMask |
               (regWrData[NPROT-1:0] & latchSel & ~cond);
         end
         if (turnOnFall) begin
            clrMask = clrMask | (latchSel & ~cond);
         end
      end
      if (s_q.hold[FI_OT] && !latchSel[FI_OT] &&
          tempDegC < OT_WARN_DEGC) begin
         clrMask[FI_OT] = 1'b1;
      end
      // set wins over clear
      newHold = (s_q.hold & ~clrMask) | cond;
      restartOk = turnOnCmd && ((s_q.hold & latchSel) == '0) &&
         !(s_q.hold[FI_OT] && tempDegC >= OT_WARN_DEGC);
   end

   always_comb begin
      s_d = s_q;
      s_d.turnOnPrev = turnOnCmd;
      s_d.hold = newHold;
      if (regWrEn && regAddr == ADDR_CFG_A) begin
         s_d.cfgA = regWrData;
      end
      if (regWrEn && regAddr == ADDR_CUR_LIMIT) begin
         s_d.curLimit = regWrData;
         // codes above the top step saturate at it
         if (regWrData[CL_MSB:0] > CL_CODE_MAX) begin
            s_d.curLimit[CL_MSB:0] = CL_CODE_MAX;
         end
      end
      unique case (s_q.state)
         PFP_IDLE: begin
            s_d.offStyle = OFF_NONE;
            if (turnOnCmd && s_q.hold == '0 && cond == '0) begin
               s_d.state = PFP_RUN;
            end
         end
         PFP_RUN: begin
            if (cond != '0) begin
               s_d.state = PFP_TRIP;
               s_d.offStyle = tripStyle;
               s_d.timer = RETRY_LOAD;
            end else if (!turnOnCmd) begin
               s_d.state = PFP_IDLE;
            end
         end
         PFP_TRIP: begin
            // a worse fault during shutdown upgrades the style
            if (tripStyle > s_q.offStyle) begin
               s_d.offStyle = tripStyle;
            end
            if (s_q.hold == (NPROT'(1) << FI_OT) &&
                !latchSel[FI_OT] && restartOk &&
                !otHot) begin
               s_d.state = PFP_RUN;
               s_d.offStyle = OFF_NONE;
            end else if (s_q.timer == '0) begin
               s_d.state = PFP_WAIT;
            end else begin
               s_d.timer = s_q.timer - TMR_W'(1);
            end
         end
         PFP_WAIT: begin
            if (tripStyle > s_q.offStyle) begin
               s_d.offStyle = tripStyle;
            end
            if (restartOk) begin
               // retry; a persisting cause trips again in run
               s_d.state = PFP_RUN;
               s_d.offStyle = OFF_NONE;
               s_d.hold = newHold & latchSel;
            end else if (!turnOnCmd && newHold == '0) begin
               s_d.state = PFP_IDLE;
            end
         end
      endcase
      s_d.run = (s_d.state == PFP_RUN);
      s_d.seqOff = !s_d.run && (s_d.offStyle == OFF_SEQ ||
         s_d.offStyle == OFF_NONE);
      s_d.fastOff = (s_d.offStyle == OFF_CRIT);
      s_d.crowbar = (s_d.offStyle == OFF_EMER);
      // a retry into a lingering cause runs one cycle before it trips again
      s_d.faultOe = !s_d.run &&
         ((newHold & propagateEn) != '0);
      unique case (regAddr)
         ADDR_CFG_A: s_d.rdData = s_q.cfgA;
         ADDR_CUR_LIMIT: s_d.rdData = s_q.curLimit;
         ADDR_STATUS: s_d.rdData = {STATUS_WARN_IDLE,
            ~s_q.hold};
         default: s_d.rdData = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.state <= PFP_IDLE;
         s_q.offStyle <= OFF_NONE;
         s_q.cfgA <= CFG_A_RESET;
         s_q.curLimit <= CUR_LIMIT_RESET;
         s_q.seqOff <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign regRdData_q = s_q.rdData;
   assign converterRun_q = s_q.run;
   assign seqOff_q = s_q.seqOff;
   assign fastOff_q = s_q.fastOff;
   assign crowbar_q = s_q.crowbar;
   assign tempCompEn_q = s_q.curLimit[BIT_TCE];
   assign curLimitCode_q = s_q.curLimit[CL_MSB:0];
   // line is only ever pulled low; its level is observed elsewhere
   assign groupFaultOut_q = 1'b0;
   assign groupFaultOe_q = s_q.faultOe;

   logic unusedGroupIn;
   assign unusedGroupIn = groupFaultIn;
endmodule : pol_fault_protection

//--- include/pfp_pkg.sv
package pfp_pkg;
   // register map
   localparam logic [7:0] ADDR_CFG_A = 8'h00;
   localparam logic [7:0] ADDR_CUR_LIMIT = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h16;
   localparam logic [7:0] CFG_A_RESET = 8'h43;
   localparam logic [7:0] CUR_LIMIT_RESET = 8'h1b;
   localparam logic [3:0] CL_CODE_MAX = 4'hb;
   localparam logic [1:0] STATUS_WARN_IDLE = 2'b11;
   // field positions
   localparam int BIT_RAMP_EN = 7;
   localparam int BIT_PHASE_EN = 6;
   localparam int BIT_TCE = 4;
   localparam int CL_MSB = 3;
   // protection index, shared by latch bits and status bits
   localparam int NPROT = 6;
   localparam int FI_PV = 0;
   localparam int FI_OV = 1;
   localparam int FI_UV = 2;
   localparam int FI_OC = 3;
   localparam int FI_OT = 4;
   localparam int FI_TR = 5;
   // analog limits in their own units (degC, mV, percent)
   localparam logic [7:0] OT_TRIP_DEGC = 8'h82;
   localparam logic [7:0] OT_WARN_DEGC = 8'h78;
   localparam logic [12:0] TRACK_WINDOW_MV = 13'h0fa;
   localparam logic [13:0] OV_FLOOR_MV = 14'h1f4;
   localparam logic [13:0] OV_MARGIN_MV = 14'h0fa;
   localparam logic [7:0] OV_PCT_110 = 8'h6e;
   localparam logic [7:0] OV_PCT_120 = 8'h78;
   localparam logic [7:0] OV_PCT_130 = 8'h82;
   localparam logic [1:0] OV_SEL_110 = 2'h0;
   localparam logic [1:0] OV_SEL_120 = 2'h1;
   localparam logic [20:0] PCT_DIV = 21'h000064;
   // retry timing
   localparam int unsigned RETRY_TIME_MS = 130;
   localparam int unsigned CLK_FREQ_HZ = 200_000_000;
   localparam int unsigned RETRY_CYCLES_DEF =
      RETRY_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int TMR_W = 25;

   typedef enum logic [1:0] {
      PFP_IDLE = 2'b00,
      PFP_RUN = 2'b01,
      PFP_TRIP = 2'b11,
      PFP_WAIT = 2'b10
   } pfp_state_type;

   // ordered by priority, higher code wins
   typedef enum logic [1:0] {
      OFF_NONE = 2'b00,
      OFF_SEQ = 2'b01,
      OFF_CRIT = 2'b10,
      OFF_EMER = 2'b11
   } pfp_off_type;
endpackage : pfp_pkg

//--- include/pfp_sync_if.sv
`timescale 1ns/1ps
interface pfp_sync_if #(parameter int W = 2);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport sink (input raw, output sync);
   modport drv (output raw, input sync);
endinterface : pfp_sync_if

//--- logic/pfp_sync.sv
`timescale 1ns/1ps
module pfp_sync #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // raw comparator levels in, clocked levels out
   pfp_sync_if.sink sp
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } pfp_sync_state_type;

   pfp_sync_state_type s_q;
   pfp_sync_state_type s_d;

   always_comb begin
      s_d = s_q;
      s_d.stage1 = sp.raw;
      s_d.stage2 = s_q.stage1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // only the second stage is visible
   assign sp.sync = s_q.stage2;
endmodule : pfp_sync

//--- verif/pfp_sva.sv
`timescale 1ns/1ps
module pfp_sva
   import pfp_pkg::*;
#(
   parameter int unsigned RETRY_CYCLES = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData_q,
   // trips and measurements
   input wire logic ocTripIn,
   input wire logic [12:0] outputMv,
   input wire logic [12:0] preBiasMv,
   input wire logic [12:0] setpointMv,
   input wire logic [7:0] tempDegC,
   input wire logic [1:0] ovLevelSel,
   // converter control
   input wire logic converterRun_q,
   input wire logic seqOff_q,
   input wire logic fastOff_q,
   input wire logic crowbar_q,
   input wire logic [CL_MSB:0] curLimitCode_q,
   input wire logic groupFaultOe_q
);
   int pct;
   int ovLim;
   logic [3:0] wrCode;
   assign wrCode = regWrData[3:0];
   assign pct = ovLevelSel == OV_SEL_110 ? 110 :
      ovLevelSel == OV_SEL_120 ? 120 : 130;
   // low setpoints would otherwise give a limit too close to nominal
   always_comb begin
      ovLim = int'(setpointMv) * pct / 100;
      if (ovLim < 500)
         ovLim = 500;
      if (ovLim < setpointMv + 250)
         ovLim = setpointMv + 250;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_reset_quiet: assert property ($past(sys_rst) |->
      !converterRun_q && seqOff_q && !groupFaultOe_q)
      else $error("converter not idle after reset");
   a_run_alone: assert property (converterRun_q |->
      !(seqOff_q || fastOff_q || crowbar_q))
      else $error("off style flag set while running");
   a_oc_cut: assert property (
      (converterRun_q && ocTripIn && outputMv > preBiasMv) [*3] |=>
      !converterRun_q && (fastOff_q || crowbar_q))
      else $error("overcurrent did not cut both switches");
   a_ov_crowbar: assert property (
      converterRun_q && outputMv > preBiasMv && outputMv > ovLim |=>
      crowbar_q && !converterRun_q)
      else $error("overvoltage did not crowbar");
   a_ot_off: assert property (
      converterRun_q && tempDegC > OT_TRIP_DEGC |=> !converterRun_q)
      else $error("overtemperature left converter on");
   a_pull_off: assert property (
      groupFaultOe_q |-> !converterRun_q)
      else $error("group line pulled while running");
   a_cfg_back: assert property (
      regWrEn && regAddr == ADDR_CFG_A ##1 regAddr == ADDR_CFG_A |=>
      regRdData_q == $past(regWrData, 2))
      else $error("config read back differs");
   a_cl_clamp: assert property (
      regWrEn && regAddr == ADDR_CUR_LIMIT |=> curLimitCode_q ==
      ($past(wrCode) > CL_CODE_MAX ? CL_CODE_MAX : $past(wrCode)))
      else $error("current limit code not clamped");
endmodule : pfp_sva

bind pol_fault_protection pfp_sva #(.RETRY_CYCLES(RETRY_CYCLES)) u_sva (
   .sys_clk, .sys_rst, .regWrEn, .regAddr, .regWrData, .regRdData_q,
   .ocTripIn, .outputMv, .preBiasMv, .setpointMv, .tempDegC, .ovLevelSel,
   .converterRun_q, .seqOff_q, .fastOff_q, .crowbar_q, .curLimitCode_q,
   .groupFaultOe_q);

//--- verif/pfp_mgr_model.sv
`timescale 1ns/1ps
module pfp_mgr_model (
   // clock
   input wire logic sys_clk,
   // manager request and peer pull
   input wire logic onReq,
   input wire logic peerPull,
   // converter side
   input wire logic dutOe,
   output logic turnOnCmd,
   output logic lineLvl
);
   initial turnOnCmd = 1'b0;
   // command only moves on an edge, as the manager's own logic would
   always @(posedge sys_clk) begin
      turnOnCmd <= onReq;
   end
   // open-drain line with pull-up: any party pulling wins
   assign lineLvl = !(dutOe || peerPull);
endmodule : pfp_mgr_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
   error_cnt++; $display("BAD %s exp %h got %h", nm, e, a); end end
module tb_top;
   import pfp_pkg::*;
   localparam int RC = 20;
   logic sys_clk = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, ocTripIn = 1'b0;
   logic phaseErrIn = 1'b0, rampingUp = 1'b0, steadyState = 1'b1;
   logic marginMove = 1'b0, onReq = 1'b0, peerPull = 1'b0;
   logic turnOnCmd, lineLvl, converterRun_q, seqOff_q, fastOff_q;
   logic crowbar_q, tempCompEn_q, groupFaultOe_q, groupFaultOut_q;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData_q;
   logic [7:0] tempDegC = 8'h19, uvPct = 8'h5a;
   logic [12:0] outputMv = 13'h3e8, preBiasMv = 13'h000;
   logic [12:0] setpointMv = 13'h3e8;
   logic [12:0] rampTargetMv = 13'h3e8;
   logic [1:0] ovLevelSel = 2'h0;
   logic [NPROT-1:0] propagateEn = '0;
   logic [CL_MSB:0] curLimitCode_q;
   int error_cnt = 0, tests_run = 0;

   always #2.5 sys_clk = ~sys_clk;

   pfp_mgr_model mgr (.sys_clk, .onReq, .peerPull,
      .dutOe(groupFaultOe_q), .turnOnCmd, .lineLvl);
   pol_fault_protection #(.RETRY_CYCLES(RC)) uut (.sys_clk, .sys_rst,
      .regWrEn, .regAddr, .regWrData, .regRdData_q, .ocTripIn, .phaseErrIn,
      .outputMv, .preBiasMv, .setpointMv, .rampTargetMv, .tempDegC,
      .ovLevelSel, .uvPct, .rampingUp, .steadyState, .marginMove,
      .turnOnCmd, .propagateEn, .converterRun_q, .seqOff_q, .fastOff_q,
      .crowbar_q, .tempCompEn_q, .curLimitCode_q, .groupFaultIn(lineLvl),
      .groupFaultOut_q, .groupFaultOe_q);

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      tick();
      regWrEn = 1'b0;
      tick();
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      regAddr = a;
      tick(2);
      `CHK("read", e, regRdData_q)
   endtask : rd

   task automatic waitRun(input logic v, input int lim);
      for (int n = 0; n < lim && converterRun_q !== v; n++) begin
         tick();
      end
   endtask : waitRun

   task automatic quiet(input string nm);
      tick(8);
      `CHK(nm, 1'b1, converterRun_q)
   endtask : quiet

   // analog faults are driven past their limits by a random distance; phase and overcurrent trip inputs are only raised
   task automatic setFault(input int k, input bit on);
      case (k)
         FI_PV: phaseErrIn = on;
         FI_OV: outputMv = on ? 13'(1251 + $urandom % 200) : 13'd1000;
         FI_UV: outputMv = on ? 13'(600 + $urandom % 300) : 13'd1000;
         FI_OC: ocTripIn = on;
         FI_OT: tempDegC = on ? 8'(131 + $urandom % 50) : 8'd25;
         default: begin
            rampingUp = on;
            steadyState = !on;
            rampTargetMv = on ? 13'(1251 + $urandom % 500) : 13'd1000;
         end
      endcase
   endtask : setFault

   task automatic tripTest(input int k);
      realtime t0;
      int cyc;
      logic ok;
      logic [2:0] sty;
      sty = k == FI_OV ? 3'h1 : (k == FI_UV || k == FI_OT) ? 3'h4 : 3'h2;
      setFault(k, 1'b1);
      waitRun(1'b0, 10);
      t0 = $realtime;
      `CHK("run", 1'b0, converterRun_q)
      `CHK("style", sty, {seqOff_q, fastOff_q, crowbar_q})
      `CHK("pull", propagateEn[k], groupFaultOe_q)
      `CHK("line", !propagateEn[k], lineLvl)
      `CHK("low", 1'b0, groupFaultOut_q)
      rd(ADDR_STATUS, 8'hff & ~(8'h01 << k));
      setFault(k, 1'b0);
      waitRun(1'b1, RC + 20);
      cyc = int'(($realtime - t0) / 5.0);
      ok = k == FI_OT ? cyc < RC : cyc >= RC && cyc <= RC + 4;
      `CHK("retry", 1'b1, ok)
      rd(ADDR_STATUS, 8'hff);
      $display("test trip %0d done", k);
   endtask : tripTest

   task automatic latchTest(input int k, input bit viaStatus);
      wr(ADDR_CFG_A, 8'hc0 | (8'h01 << k));
      setFault(k, 1'b1);
      waitRun(1'b0, 10);
      setFault(k, 1'b0);
      tick(RC + 10);
      `CHK("latched", 1'b0, converterRun_q)
      rd(ADDR_STATUS, 8'hff & ~(8'h01 << k));
      if (viaStatus) begin
         wr(ADDR_STATUS, 8'h01 << k);
      end else begin
         onReq = 1'b0;
         tick(3);
         onReq = 1'b1;
      end
      waitRun(1'b1, 10);
      `CHK("relaunch", 1'b1, converterRun_q)
      rd(ADDR_STATUS, 8'hff);
      wr(ADDR_CFG_A, 8'hc0);
      $display("test latch %0d done", k);
   endtask : latchTest

   // whole run needs about 300 cycles
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      int ks[$] = '{FI_PV, FI_OV, FI_UV, FI_OC, FI_OT, FI_TR};
      logic [7:0] r;
      logic [3:0] e4;
      void'($urandom(4));
      propagateEn = NPROT'($urandom) | 6'h01;
      tick(3);
      sys_rst = 1'b0;
      rd(ADDR_CFG_A, CFG_A_RESET);
      rd(ADDR_CUR_LIMIT, CUR_LIMIT_RESET);
      rd(ADDR_STATUS, 8'hff);
      r = 8'($urandom);
      wr(ADDR_CFG_A, r);
      rd(ADDR_CFG_A, r);
      wr(8'h05, 8'haa);
      rd(8'h05, 8'h00);
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom);
         e4 = r[3:0] > CL_CODE_MAX ? CL_CODE_MAX : r[3:0];
         wr(ADDR_CUR_LIMIT, r);
         `CHK("tce", r[BIT_TCE], tempCompEn_q)
         `CHK("cl", e4, curLimitCode_q)
      end
      $display("test regs done");
      wr(ADDR_CFG_A, 8'hc0);
      onReq = 1'b1;
      waitRun(1'b1, 10);
      `CHK("start", 1'b1, converterRun_q)
      marginMove = 1'b1;
      setFault(FI_TR, 1'b1);
      quiet("margin");
      wr(ADDR_CFG_A, 8'h40);
      marginMove = 1'b0;
      quiet("trdis");
      setFault(FI_TR, 1'b0);
      wr(ADDR_CFG_A, 8'h80);
      setFault(FI_PV, 1'b1);
      quiet("pvdis");
      setFault(FI_PV, 1'b0);
      tick(4);
      wr(ADDR_CFG_A, 8'hc0);
      preBiasMv = 13'd1200;
      setFault(FI_OC, 1'b1);
      quiet("prebias");
      setFault(FI_OC, 1'b0);
      tick(4);
      preBiasMv = 13'd0;
      ovLevelSel = 2'h2;
      outputMv = 13'h50a;
      rampTargetMv = 13'h7d0;
      quiet("steady");
      setFault(FI_OV, 1'b0);
      rampTargetMv = 13'h3e8;
      ovLevelSel = 2'h0;
      steadyState = 1'b0;
      setFault(FI_UV, 1'b1);
      quiet("rampuv");
      setFault(FI_UV, 1'b0);
      steadyState = 1'b1;
      $display("test gating done");
      foreach (ks[i]) begin
         tripTest(ks[i]);
      end
      latchTest(FI_OV, 1'b1);
      latchTest(FI_OC, 1'b0);
      give_verdict();
   end
endmodule : tb_top
